// ===== mbh_map.svh
`ifndef MBH_MAP_SVH
`define MBH_MAP_SVH

// clock period and internal access time, both in ns
`define MBH_CLK_PERIOD_NS 10
`define MBH_ACCESS_NS 10

// field positions inside the composed 20-bit host address
`define MBH_HI_ADDR_LSB 16
`define MBH_BURST_LOW_BITS 4

// reset values
`define MBH_RST_BYTE 8'h00
`define MBH_RST_ADDR 20'h00000

`endif

// ===== mbh_pkg.sv
package mbh_pkg;

    // strobe styles: separate write/read/fetch, single read, direction plus strobe
    typedef enum logic [1:0] {
        MBH_STYLE_SEP,
        MBH_STYLE_ONE_RD,
        MBH_STYLE_DIR
    } mbh_style_t;

    typedef enum logic {
        MBH_BUS_MUX,
        MBH_BUS_NONMUX
    } mbh_bus_t;

    typedef struct packed {
        mbh_style_t style;
        mbh_bus_t bus;
        logic page;
        logic burst;
        logic ds_low;
    } mbh_cfg_t;

    typedef enum logic [1:0] {
        MBH_RD_IDLE,
        MBH_RD_WAIT,
        MBH_RD_DRIVE
    } mbh_rd_state_t;

endpackage : mbh_pkg

// ===== mbh_sync.sv
`timescale 1ns/1ns
`default_nettype none

module mbh_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    if (W < 1) begin : g_bad_width
        $error("mbh_sync width must be at least one");
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                meta_q <= 1'b0;
                q_out[i] <= 1'b0;
            end else begin
                meta_q <= d_in[i];
                q_out[i] <= meta_q;
            end
        end
    end
endmodule : mbh_sync

`default_nettype wire

// ===== mbh_addr_latch.sv
`timescale 1ns/1ns
`default_nettype none

module mbh_addr_latch #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    if (W < 1) begin : g_bad_width
        $error("mbh_addr_latch width must be at least one");
    end

    // loads on every clock while the strobe is high, holds from its fall onward
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_out <= '0;
        end else if (en_in) begin
            q_out <= d_in;
        end
    end
endmodule : mbh_addr_latch

`default_nettype wire

// ===== mbh_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "mbh_map.svh"

// Function
// - bus style frozen from configuration at reset
// - separate strobes: write zero, read one, fetch two
// - direction on zero, data strobe on one
// - latch address on address strobe, hold it
// - drive data only on selected read
// - latched address can appear on ports A/B
// - port pins extend multiplexed address above fifteen, except in burst
// - non-multiplexed: address on port, data on A
// - non-multiplexed: port A floats unless host accesses
// - port pins extend non-multiplexed address too
// - address strobe unused on non-multiplexed bus
// - high byte enable ignored, bit zero selects
// - unused control two feeds general logic
// - single read: fetch strobe on control one
// - non-page: latch address every bus cycle
// - page hit keeps latched upper address
// - page mode rereads on low address change
// - burst: low four bits never multiplexed
// - burst holds upper bits, steps low four
// - direction style yields separate external strobes
// - address strobe captures bits above fifteen
module mbh_bus_if (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire mbh_pkg::mbh_cfg_t CFG_IN,
    input wire logic ADDR_OUT_EN_IN,
    input wire logic CONTROL_INPUT_ZERO_IN,
    input wire logic CONTROL_INPUT_ONE_IN,
    input wire logic CONTROL_INPUT_TWO_IN,
    input wire logic ADDRESS_LATCH_STROBE_IN,
    input wire logic [15:0] ADDR_DATA_PORT_IN,
    output logic [7:0] ADDR_DATA_PORT_OUT,
    output logic ADDR_DATA_PORT_OE_OUT,
    input wire logic [7:0] PORT_A_IN,
    output logic [7:0] PORT_A_OUT,
    output logic PORT_A_OE_OUT,
    output logic [7:0] PORT_B_OUT,
    output logic PORT_B_OE_OUT,
    input wire logic [3:0] PORT_C_IN,
    output logic ACC_RD_OUT,
    output logic ACC_WR_OUT,
    output logic [19:0] ACC_ADDR_OUT,
    output logic ACC_ODD_BYTE_OUT,
    output logic [7:0] ACC_WDATA_OUT,
    input wire logic [7:0] ACC_RDATA_IN,
    input wire logic ACC_SEL_IN,
    output logic EXT_RD_STROBE_OUT,
    output logic EXT_WR_STROBE_OUT,
    output logic GEN_LOGIC_TWO_OUT
);
    import mbh_pkg::*;

    localparam int AccCycRaw =
        (`MBH_ACCESS_NS + `MBH_CLK_PERIOD_NS - 1) / `MBH_CLK_PERIOD_NS;
    localparam int AccCyc = (AccCycRaw < 1) ? 1 : AccCycRaw;
    localparam logic [3:0] AccCycW = 4'(AccCyc);

    if (AccCyc > 15) begin : g_bad_access
        $error("access time exceeds the wait counter");
    end

    mbh_cfg_t cfg_q;
    logic [31:0] raw_pins;
    logic [31:0] s_pins;
    logic [15:0] s_addr_data_port;
    logic [7:0] s_pa;
    logic [3:0] s_pc;
    logic [2:0] s_ctl;
    logic s_ale;
    logic mux_bus;
    logic lat_en;
    logic [15:0] lat;
    logic [3:0] hi_lat;
    logic [19:0] addr;
    logic [7:0] din;
    logic rd_act;
    logic wr_act;
    logic strb;
    logic rd_prev_q;
    logic wr_prev_q;
    logic rd_start;
    logic cap;
    mbh_rd_state_t state_q;
    logic [3:0] cnt_q;
    logic sel_q;
    logic drive_d;
    logic [1:0] warm_q;

    // every pin crosses into the clock domain before any decode looks at it
    assign raw_pins = {ADDR_DATA_PORT_IN, PORT_A_IN, PORT_C_IN,
                       CONTROL_INPUT_TWO_IN, CONTROL_INPUT_ONE_IN,
                       CONTROL_INPUT_ZERO_IN, ADDRESS_LATCH_STROBE_IN};

    mbh_sync #(.W(32)) u_sync (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(raw_pins),
        .q_out(s_pins)
    );

    assign s_addr_data_port = s_pins[31:16];
    assign s_pa = s_pins[15:8];
    assign s_pc = s_pins[7:4];
    assign s_ctl = s_pins[3:1];
    assign s_ale = s_pins[0];

    // configuration is sampled only while reset is held, never at run time
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            cfg_q <= CFG_IN;
        end
    end

    assign mux_bus = (cfg_q.bus == MBH_BUS_MUX);
    // the strobe is ignored on a non-multiplexed bus
    assign lat_en = s_ale & mux_bus;

    mbh_addr_latch #(.W(16)) u_lat_lo (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .en_in(lat_en),
        .d_in(s_addr_data_port),
        .q_out(lat)
    );

    mbh_addr_latch #(.W(4)) u_lat_hi (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .en_in(lat_en),
        .d_in(s_pc),
        .q_out(hi_lat)
    );

    // compose the 20-bit host address for each bus shape
    always_comb begin
        addr = `MBH_RST_ADDR;
        unique case (cfg_q.bus)
            MBH_BUS_NONMUX: begin
                addr = {s_pc, s_addr_data_port};
            end
            MBH_BUS_MUX: begin
                if (cfg_q.burst) begin
                    addr = {lat, s_pa[`MBH_BURST_LOW_BITS-1:0]};
                end else if (cfg_q.page) begin
                    addr = {hi_lat, lat[7:0], s_addr_data_port[15:8]};
                end else begin
                    addr = {hi_lat, lat};
                end
            end
        endcase
    end

    assign din = mux_bus ? s_addr_data_port[7:0] : s_pa;

    // strobe decode; the separate-strobe styles use active-low pins
    assign strb = cfg_q.ds_low ? ~s_ctl[1] : s_ctl[1];

    // the synchroniser clears to zero while active-low strobes idle high, so
    // decode waits until real pin levels have crossed both flops; without this
    // a false strobe edge would follow every reset
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            warm_q <= 2'b00;
        end else begin
            warm_q <= {warm_q[0], 1'b1};
        end
    end

    always_comb begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        unique case (cfg_q.style)
            MBH_STYLE_SEP: begin
                wr_act = ~s_ctl[0];
                rd_act = ~s_ctl[1] | ~s_ctl[2];
            end
            MBH_STYLE_ONE_RD: begin
                wr_act = ~s_ctl[0];
                rd_act = ~s_ctl[1];
            end
            MBH_STYLE_DIR: begin
                rd_act = strb & s_ctl[0];
                wr_act = strb & ~s_ctl[0];
            end
            default: begin
                rd_act = 1'b0;
                wr_act = 1'b0;
            end
        endcase
        if (!warm_q[1]) begin
            rd_act = 1'b0;
            wr_act = 1'b0;
        end
    end

    // page and burst hosts change only low bits inside one strobe
    assign rd_start = rd_act & (~rd_prev_q |
        ((cfg_q.page | cfg_q.burst) & mux_bus & (addr != ACC_ADDR_OUT)));
    assign cap = rd_act & ~rd_start & (state_q == MBH_RD_WAIT) & (cnt_q == 4'h0);
    assign drive_d = rd_act & ~rd_start &
        (((state_q == MBH_RD_DRIVE) & sel_q) | (cap & ACC_SEL_IN));

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            rd_prev_q <= rd_act;
            wr_prev_q <= wr_act;
        end
    end

    // read sequencer: wait the access time, then hold data until the strobe ends
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            state_q <= MBH_RD_IDLE;
            cnt_q <= 4'h0;
        end else if (!rd_act) begin
            state_q <= MBH_RD_IDLE;
            cnt_q <= 4'h0;
        end else if (rd_start) begin
            state_q <= MBH_RD_WAIT;
            cnt_q <= AccCycW;
        end else if (state_q == MBH_RD_WAIT) begin
            if (cnt_q == 4'h0) begin
                state_q <= MBH_RD_DRIVE;
            end else begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            ACC_RD_OUT <= 1'b0;
            ACC_WR_OUT <= 1'b0;
        end else begin
            ACC_RD_OUT <= rd_start;
            // writes fire on the trailing edge so the data has settled
            ACC_WR_OUT <= wr_prev_q & ~wr_act;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            ACC_ADDR_OUT <= `MBH_RST_ADDR;
            ACC_ODD_BYTE_OUT <= 1'b0;
            ACC_WDATA_OUT <= `MBH_RST_BYTE;
        end else if (rd_start || wr_act) begin
            ACC_ADDR_OUT <= addr;
            // the high byte enable plays no part on an 8-bit bus
            ACC_ODD_BYTE_OUT <= addr[0];
            if (wr_act) begin
                ACC_WDATA_OUT <= din;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            sel_q <= 1'b0;
            ADDR_DATA_PORT_OUT <= `MBH_RST_BYTE;
        end else if (cap) begin
            sel_q <= ACC_SEL_IN;
            ADDR_DATA_PORT_OUT <= ACC_RDATA_IN;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            ADDR_DATA_PORT_OE_OUT <= 1'b0;
            PORT_A_OE_OUT <= 1'b0;
            PORT_A_OUT <= `MBH_RST_BYTE;
            PORT_B_OUT <= `MBH_RST_BYTE;
            PORT_B_OE_OUT <= 1'b0;
        end else begin
            ADDR_DATA_PORT_OE_OUT <= drive_d & mux_bus;
            PORT_B_OE_OUT <= ADDR_OUT_EN_IN;
            PORT_B_OUT <= mux_bus ? addr[15:8] : addr[7:0];
            if (mux_bus) begin
                PORT_A_OE_OUT <= ADDR_OUT_EN_IN;
                PORT_A_OUT <= addr[7:0];
            end else begin
                PORT_A_OE_OUT <= drive_d;
                if (cap) begin
                    PORT_A_OUT <= ACC_RDATA_IN;
                end
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            EXT_RD_STROBE_OUT <= 1'b0;
            EXT_WR_STROBE_OUT <= 1'b0;
            GEN_LOGIC_TWO_OUT <= 1'b0;
        end else begin
            EXT_RD_STROBE_OUT <= rd_act & (cfg_q.style == MBH_STYLE_DIR);
            EXT_WR_STROBE_OUT <= wr_act & (cfg_q.style == MBH_STYLE_DIR);
            GEN_LOGIC_TWO_OUT <= s_ctl[2] & (cfg_q.style != MBH_STYLE_SEP);
        end
    end

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    chk_cfg_frozen: assert property (!SYS_RST_IN |=> $stable(cfg_q))
        else $error("configuration changed outside reset");
    chk_rd_pulse_once: assert property (ACC_RD_OUT && !$past(rd_start) |-> 1'b0)
        else $error("read pulse without a read start");
    chk_rd_on_rise: assert property ($rose(rd_act) |=> ACC_RD_OUT)
        else $error("read strobe did not start an access");
    chk_wr_trailing: assert property ($fell(wr_act) |=> ACC_WR_OUT ##1 !ACC_WR_OUT)
        else $error("write access not one pulse after strobe end");
    chk_drive_rd_only: assert property (ADDR_DATA_PORT_OE_OUT |-> $past(rd_act) && mux_bus)
        else $error("data port driven without a read");
    chk_porta_float: assert property (!mux_bus && !$past(rd_act) |-> !PORT_A_OE_OUT)
        else $error("port A driven while not accessed");
    chk_latch_hold: assert property (!lat_en |=> $stable(lat) && $stable(hi_lat))
        else $error("latched address moved without strobe");
    chk_odd_byte: assert property (ACC_ODD_BYTE_OUT == ACC_ADDR_OUT[0])
        else $error("byte select differs from address bit zero");
    chk_data_delay: assert property (ACC_RD_OUT && rd_act && !rd_start
        ##1 rd_act && !rd_start
        |=> sel_q == $past(ACC_SEL_IN) && ADDR_DATA_PORT_OUT == $past(ACC_RDATA_IN))
        else $error("read data not taken after access time");
    chk_no_early_access: assert property ($fell(SYS_RST_IN) |->
        (!ACC_RD_OUT && !ACC_WR_OUT) [*3])
        else $error("access pulse right after reset release");
    chk_dir_strobe: assert property (rd_act && cfg_q.style == MBH_STYLE_DIR
        |=> EXT_RD_STROBE_OUT && !EXT_WR_STROBE_OUT)
        else $error("external read strobe missing");

    cov_read_drive: cover property (ACC_RD_OUT ##[1:4] ADDR_DATA_PORT_OE_OUT);
    cov_nonmux_read: cover property (PORT_A_OE_OUT && !mux_bus);
    cov_page_reread: cover property (rd_act && rd_prev_q && rd_start);
    cov_write: cover property (ACC_WR_OUT);
    cov_low_strobe: cover property (EXT_WR_STROBE_OUT && cfg_q.ds_low);
endmodule : mbh_bus_if

`default_nettype wire

// ===== mbh_bus_if_end.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== mbh_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module mbh_host_model (
    input wire logic clk_in,
    input wire mbh_pkg::mbh_cfg_t cfg_in,
    input wire logic [7:0] dev_addr_data_port_in,
    input wire logic dev_addr_data_port_oe_in,
    input wire logic [7:0] dev_pa_in,
    input wire logic dev_pa_oe_in,
    output logic ctl0_out,
    output logic ctl1_out,
    output logic ctl2_out,
    output logic ale_out,
    output logic [15:0] addr_data_port_out,
    output logic [7:0] pa_out,
    output logic [3:0] pc_out
);
    import mbh_pkg::*;
    logic [15:0] addr_data_port_q;
    logic [7:0] pa_q;
    logic [7:0] got [16];

    // wire level: the device owns the data byte only while it drives it
    assign addr_data_port_out = {addr_data_port_q[15:8], dev_addr_data_port_oe_in ? dev_addr_data_port_in : addr_data_port_q[7:0]};
    assign pa_out = dev_pa_oe_in ? dev_pa_in : pa_q;

    initial begin
        ctl0_out = 1'b1;
        ctl1_out = 1'b1;
        ctl2_out = 1'b1;
        ale_out = 1'b0;
        addr_data_port_q = 16'h0000;
        pa_q = 8'h00;
        pc_out = 4'h0;
    end

    task automatic idle();
        @(posedge clk_in);
        ctl0_out <= 1'b1;
        ctl1_out <= (cfg_in.style == MBH_STYLE_DIR) ? cfg_in.ds_low : 1'b1;
        ctl2_out <= 1'b1;
    endtask : idle

    task automatic set2(input logic v);
        @(posedge clk_in);
        ctl2_out <= v;
    endtask : set2

    task automatic strobe(input int pin, input logic on);
        if (cfg_in.style == MBH_STYLE_DIR) ctl1_out <= on ^ cfg_in.ds_low;
        else if (pin == 0) ctl0_out <= ~on;
        else if (pin == 1) ctl1_out <= ~on;
        else ctl2_out <= ~on;
    endtask : strobe

    task automatic latch(input logic [15:0] w, input logic [3:0] hi);
        ale_out <= 1'b1;
        addr_data_port_q <= w;
        pc_out <= hi;
        repeat (3) @(posedge clk_in);
        ale_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        // released lines flip so only the latch can supply the upper bits
        pc_out <= ~hi;
    endtask : latch

    task automatic cycle(input logic rd, input int pin, input logic [19:0] a,
                         input logic [7:0] wd, input logic ale,
                         output logic [7:0] rv, output logic oe);
        logic mux;
        mux = cfg_in.bus == MBH_BUS_MUX;
        @(posedge clk_in);
        if (cfg_in.style == MBH_STYLE_DIR) ctl0_out <= rd;
        if (!mux) begin
            addr_data_port_q <= a[15:0];
            pc_out <= a[19:16];
            pa_q <= rd ? ~pa_q : wd;
        end else if (ale) begin
            latch(cfg_in.page ? {a[7:0], a[15:8]} : a[15:0], a[19:16]);
            addr_data_port_q[7:0] <= rd ? ~addr_data_port_q[7:0] : wd;
        end else begin
            addr_data_port_q <= {a[7:0], rd ? ~addr_data_port_q[7:0] : wd};
        end
        repeat (2) @(posedge clk_in);
        strobe(pin, 1'b1);
        repeat (8) @(posedge clk_in);
        #1;
        rv = mux ? addr_data_port_out[7:0] : pa_out;
        oe = mux ? dev_addr_data_port_oe_in : dev_pa_oe_in;
        @(posedge clk_in);
        strobe(pin, 1'b0);
        repeat (5) @(posedge clk_in);
        if (cfg_in.style == MBH_STYLE_DIR) ctl0_out <= 1'b1;
        addr_data_port_q[7:0] <= ~addr_data_port_q[7:0];
        pa_q <= ~pa_q;
        #1;
    endtask : cycle

    task automatic burst(input logic [19:0] a);
        @(posedge clk_in);
        pa_q[3:0] <= a[3:0];
        latch(a[19:4], 4'h0);
        addr_data_port_q[7:0] <= ~addr_data_port_q[7:0];
        repeat (2) @(posedge clk_in);
        strobe(1, 1'b1);
        for (int i = 0; i < 16; i++) begin
            pa_q[3:0] <= a[3:0] + 4'(i);
            repeat (8) @(posedge clk_in);
            #1;
            got[i] = addr_data_port_out[7:0];
            @(posedge clk_in);
        end
        strobe(1, 1'b0);
        repeat (5) @(posedge clk_in);
        addr_data_port_q[7:0] <= ~addr_data_port_q[7:0];
        #1;
    endtask : burst
endmodule : mbh_host_model

`default_nettype wire

// ===== mbh_tb.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import mbh_pkg::*;
    mbh_cfg_t CFG_IN, hcfg;
    logic MCLK_IN, SYS_RST_IN, ADDR_OUT_EN_IN, ACC_SEL_IN, ctl0, ctl1, ctl2, ale;
    logic [15:0] addr_data_port;
    logic [7:0] pa, ACC_RDATA_IN, ADDR_DATA_PORT_OUT, PORT_A_OUT, PORT_B_OUT, ACC_WDATA_OUT;
    logic [7:0] wd;
    logic [3:0] pc;
    logic [19:0] ACC_ADDR_OUT, wa, ra;
    logic ADDR_DATA_PORT_OE_OUT, PORT_A_OE_OUT, PORT_B_OE_OUT, ACC_RD_OUT, ACC_WR_OUT;
    logic ACC_ODD_BYTE_OUT, EXT_RD_STROBE_OUT, EXT_WR_STROBE_OUT, GEN_LOGIC_TWO_OUT, wodd;
    int mismatches = 0, checks = 0, cyc = 0, rd_n = 0, wr_n = 0, erd_n = 0, ewr_n = 0;
    int e0, f0, n0;

    mbh_bus_if uut (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .CFG_IN(CFG_IN),
        .ADDR_OUT_EN_IN(ADDR_OUT_EN_IN), .CONTROL_INPUT_ZERO_IN(ctl0),
        .CONTROL_INPUT_ONE_IN(ctl1), .CONTROL_INPUT_TWO_IN(ctl2),
        .ADDRESS_LATCH_STROBE_IN(ale), .ADDR_DATA_PORT_IN(addr_data_port),
        .ADDR_DATA_PORT_OUT(ADDR_DATA_PORT_OUT), .ADDR_DATA_PORT_OE_OUT(ADDR_DATA_PORT_OE_OUT),
        .PORT_A_IN(pa), .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE_OUT(PORT_A_OE_OUT),
        .PORT_B_OUT(PORT_B_OUT), .PORT_B_OE_OUT(PORT_B_OE_OUT), .PORT_C_IN(pc),
        .ACC_RD_OUT(ACC_RD_OUT), .ACC_WR_OUT(ACC_WR_OUT), .ACC_ADDR_OUT(ACC_ADDR_OUT),
        .ACC_ODD_BYTE_OUT(ACC_ODD_BYTE_OUT), .ACC_WDATA_OUT(ACC_WDATA_OUT),
        .ACC_RDATA_IN(ACC_RDATA_IN), .ACC_SEL_IN(ACC_SEL_IN),
        .EXT_RD_STROBE_OUT(EXT_RD_STROBE_OUT), .EXT_WR_STROBE_OUT(EXT_WR_STROBE_OUT),
        .GEN_LOGIC_TWO_OUT(GEN_LOGIC_TWO_OUT));

    mbh_host_model host (.clk_in(MCLK_IN), .cfg_in(hcfg), .dev_addr_data_port_in(ADDR_DATA_PORT_OUT),
        .dev_addr_data_port_oe_in(ADDR_DATA_PORT_OE_OUT), .dev_pa_in(PORT_A_OUT),
        .dev_pa_oe_in(PORT_A_OE_OUT), .ctl0_out(ctl0), .ctl1_out(ctl1), .ctl2_out(ctl2),
        .ale_out(ale), .addr_data_port_out(addr_data_port), .pa_out(pa), .pc_out(pc));

    always #5 MCLK_IN = ~MCLK_IN;

    function automatic logic [7:0] dat(input logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ {a[19:16], a[19:16]};
    endfunction : dat

    function automatic mbh_cfg_t mk(input mbh_style_t s, input mbh_bus_t b, input logic pg,
                                    input logic bu);
        return '{style: s, bus: b, page: pg, burst: bu, ds_low: 1'b0};
    endfunction : mk

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    // decode stand-in answers one cycle after the access address; bits 15:12 equal to f are unmapped
    always @(posedge MCLK_IN) begin
        ACC_RDATA_IN <= dat(ACC_ADDR_OUT);
        ACC_SEL_IN <= ACC_ADDR_OUT[15:12] != 4'hf;
        if (ACC_RD_OUT === 1'b1) begin
            rd_n++;
            ra = ACC_ADDR_OUT;
        end
        if (ACC_WR_OUT === 1'b1) begin
            wr_n++;
            wa = ACC_ADDR_OUT;
            wd = ACC_WDATA_OUT;
            wodd = ACC_ODD_BYTE_OUT;
        end
        if (EXT_RD_STROBE_OUT === 1'b1) erd_n++;
        if (EXT_WR_STROBE_OUT === 1'b1) ewr_n++;
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            $display("[ERR] %0t run too long", $time);
            test_done();
        end
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: %h vs %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic start(input mbh_cfg_t c, input logic en);
        @(posedge MCLK_IN);
        CFG_IN <= c;
        hcfg <= c;
        ADDR_OUT_EN_IN <= en;
        SYS_RST_IN <= 1'b1;
        host.idle();
        repeat (5) @(posedge MCLK_IN);
        SYS_RST_IN <= 1'b0;
        repeat (3) @(posedge MCLK_IN);
    endtask : start

    task automatic rd(input int pin, input logic [19:0] a, input logic sel, input logic ale);
        logic [7:0] rv;
        logic oe;
        int n;
        n = rd_n;
        host.cycle(1'b1, pin, a, 8'h00, ale, rv, oe);
        chk(20'(oe), 20'(sel), "drive");
        if (sel) chk(20'(rv), 20'(dat(a)), "rdata");
        chk(20'(rd_n - n), 20'h1, "rd count");
        chk(ra, a, "rd addr");
        chk(20'({ADDR_DATA_PORT_OE_OUT, PORT_A_OE_OUT && hcfg.bus == MBH_BUS_NONMUX}),
            20'h0, "float");
    endtask : rd

    task automatic wr(input int pin, input logic [19:0] a, input logic [7:0] d);
        logic [7:0] rv;
        logic oe;
        int n;
        n = wr_n;
        host.cycle(1'b0, pin, a, d, 1'b1, rv, oe);
        chk(20'(wr_n - n), 20'h1, "wr count");
        chk(wa, a, "wr addr");
        chk(20'({wd, wodd}), 20'({d, a[0]}), "wr data");
    endtask : wr

    initial begin
        MCLK_IN = 1'b0;
        SYS_RST_IN = 1'b1;
        ADDR_OUT_EN_IN = 1'b0;
        CFG_IN = mk(MBH_STYLE_SEP, MBH_BUS_MUX, 1'b0, 1'b0);
        hcfg = CFG_IN;
        ACC_RDATA_IN = 8'h00;
        ACC_SEL_IN = 1'b0;
        start(mk(MBH_STYLE_SEP, MBH_BUS_MUX, 1'b0, 1'b0), 1'b1);
        // style must stay as captured in reset
        CFG_IN <= mk(MBH_STYLE_DIR, MBH_BUS_NONMUX, 1'b0, 1'b0);
        wr(0, 20'h5a3c1, 8'h96);
        wr(0, 20'h5a3c0, 8'h69);
        rd(1, 20'h3b2c4, 1'b1, 1'b1);
        chk(20'({PORT_B_OUT, PORT_A_OUT, PORT_A_OE_OUT, PORT_B_OE_OUT}),
            20'({16'hb2c4, 2'b11}), "addr out");
        rd(2, 20'h7e1a5, 1'b1, 1'b1);
        rd(1, 20'h0f0ab, 1'b0, 1'b1);
        $display("test separate strobes done");
        start(mk(MBH_STYLE_ONE_RD, MBH_BUS_MUX, 1'b0, 1'b0), 1'b0);
        wr(0, 20'h2104e, 8'h5d);
        rd(1, 20'h2104e, 1'b1, 1'b1);
        chk(20'(PORT_B_OE_OUT), 20'h0, "addr out off");
        for (int v = 0; v < 2; v++) begin
            host.set2(v[0]);
            repeat (4) @(posedge MCLK_IN);
            #1;
            chk(20'(GEN_LOGIC_TWO_OUT), 20'(v), "ctl2 pass");
        end
        $display("test single read done");
        start(mk(MBH_STYLE_DIR, MBH_BUS_MUX, 1'b0, 1'b0), 1'b0);
        e0 = erd_n;
        f0 = ewr_n;
        rd(1, 20'h6a0f3, 1'b1, 1'b1);
        chk(20'({erd_n > e0, ewr_n == f0}), 20'h3, "ext rd");
        wr(1, 20'h6a0f2, 8'hc3);
        chk(20'(ewr_n > f0), 20'h1, "ext wr");
        $display("test direction strobe done");
        start('{style: MBH_STYLE_DIR, bus: MBH_BUS_MUX, page: 1'b0, burst: 1'b0,
            ds_low: 1'b1}, 1'b0);
        e0 = erd_n;
        f0 = ewr_n;
        rd(1, 20'h6b0f1, 1'b1, 1'b1);
        wr(1, 20'h6b0f0, 8'h3c);
        chk(20'({erd_n > e0, ewr_n > f0}), 20'h3, "ext low strobes");
        $display("test low data strobe done");
        start(mk(MBH_STYLE_SEP, MBH_BUS_NONMUX, 1'b0, 1'b0), 1'b1);
        wr(0, 20'h9c355, 8'h3e);
        rd(1, 20'h9c356, 1'b1, 1'b1);
        chk(20'(PORT_B_OUT), 20'h56, "addr out");
        $display("test non-multiplexed done");
        start(mk(MBH_STYLE_SEP, MBH_BUS_MUX, 1'b1, 1'b0), 1'b0);
        rd(1, 20'h41234, 1'b1, 1'b1);
        rd(1, 20'h41235, 1'b1, 1'b0);
        rd(1, 20'h412fe, 1'b1, 1'b0);
        $display("test page mode done");
        start(mk(MBH_STYLE_SEP, MBH_BUS_MUX, 1'b0, 1'b1), 1'b0);
        n0 = rd_n;
        host.burst(20'h12340);
        for (int i = 0; i < 16; i++) begin
            chk(20'(host.got[i]), 20'(dat(20'h12340 + 20'(i))), "burst");
        end
        chk(20'(rd_n - n0), 20'h10, "burst count");
        $display("test burst done");
        test_done();
    end
endmodule : testbench

`default_nettype wire
